// [src/gpc_cfg.svh]
/*
  Register offsets, field positions, reset values and pin masks for the
  port control block. Assumes it is included by the package and the modules.
*/
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// port geometry
`define GPC_NUM_PORTS   15
`define GPC_PORT_PINS   120
`define GPC_PU_GROUPS   30
`define GPC_GROUP_PINS  4
`define GPC_EXT_FIRST   11
`define GPC_BUS_LAST    5

// register byte addresses
`define GPC_DIR_BASE    10'h3C8
`define GPC_DATA_BASE   10'h3E8
`define GPC_PORT8_DATA  10'h3F0
`define GPC_PUR_BASE    10'h3F8
`define GPC_PORT_CTRL   10'h3FC
`define GPC_WR_PROTECT  10'h3FD
`define GPC_PROC_MODE   10'h3FE
`define GPC_LAST_IDX    10'h00E

// port indices with special handling
`define GPC_PORT1       4'h1
`define GPC_PORT8       4'h8
`define GPC_PORT9       4'h9

// field positions
`define GPC_EXT_EN_BIT  7
`define GPC_BUS_PU_BIT  1
`define GPC_LATCH_RB    0
`define GPC_PROT_REL_BIT 2
`define GPC_BCLK_OFF    7
`define GPC_NMI_BIT     5
`define GPC_NMI_PIN     69

// reset values of pullup_select_reg_b
`define GPC_PURB_SINGLE 8'h00
`define GPC_PURB_BUS    8'h02

// pin masks over the flat 120-pin vector
`define GPC_BUS_PU_MASK 120'hFF0FFFFFFFFF
`define GPC_LOCK_MASK   120'hFFFFFFFFFFFF
`define GPC_NOPU_MASK   120'h200300000000000000
`define GPC_OD_MASK     120'h0300000000000000
`define GPC_INONLY_MASK 120'h200000000000000000

`endif

// [src/gpc_pkg.sv]
/*
  Types of the port control block: mode encodings, phases and the state
  records of both modules. Assumes gpc_cfg.svh is on the include path.
*/
`include "gpc_cfg.svh"

package gpc_pkg;

  typedef enum logic [1:0] {
    PM_SINGLE = 2'h0,
    PM_EXPAND = 2'h1,
    PM_RSVD   = 2'h2,
    PM_MICRO  = 2'h3
  } gpc_mode_t;

  typedef enum logic {
    PH_STRAP = 1'h0,
    PH_RUN   = 1'h1
  } gpc_phase_t;

  typedef struct packed {
    gpc_phase_t                        phase;
    gpc_mode_t                         pmode;
    logic                              busClkOff;
    logic [`GPC_NUM_PORTS-1:0][7:0]    dir;
    logic [`GPC_NUM_PORTS-1:0][7:0]    latch;
    logic [3:0][7:0]                   pur;
    logic                              latchRb;
    logic                              protRel;
    logic [7:0]                        rdata;
  } gpc_ctrl_t;

  typedef struct packed {
    logic [`GPC_PORT_PINS-1:0] out;
    logic [`GPC_PORT_PINS-1:0] oe;
    logic [`GPC_PORT_PINS-1:0] pu;
  } gpc_pin_t;

endpackage : gpc_pkg

// [src/gpc_pin_stage.sv]
/*
  Pin stage: turns direction, latch and pull-up selections into registered
  pin drive, enable and pull-up controls. Assumes its inputs are the next
  register values of the control core, so pins follow on the write edge.
*/
`timescale 1ns/100ps
`default_nettype none

module gpc_pin_stage
  import gpc_pkg::*;
(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  // register image
  input  wire logic [`GPC_PORT_PINS-1:0] dir,
  input  wire logic [`GPC_PORT_PINS-1:0] latch,
  input  wire logic [31:0]               pur,
  input  wire logic                      busMode,
  // pin controls
  output logic [`GPC_PORT_PINS-1:0]      pinOut,
  output logic [`GPC_PORT_PINS-1:0]      pinOe,
  output logic [`GPC_PORT_PINS-1:0]      pinPullup
);

  gpc_pin_t pin_ff;
  gpc_pin_t nxt_pin;

  // per-pin drive and pull-up decisions
  always_comb begin
    logic [`GPC_PORT_PINS-1:0] grp;
    grp = '0;
    for (int g = 0; g < `GPC_PU_GROUPS; g++) begin
      grp[g*`GPC_GROUP_PINS +: `GPC_GROUP_PINS] = {`GPC_GROUP_PINS{pur[g]}};
    end
    nxt_pin.pu  = grp & ~dir & ~`GPC_NOPU_MASK
                & ~(busMode ? `GPC_BUS_PU_MASK : '0);
    nxt_pin.oe  = dir & ~`GPC_INONLY_MASK
                & ~(busMode ? `GPC_LOCK_MASK : '0)
                & ~(`GPC_OD_MASK & latch);
    nxt_pin.out = latch & ~`GPC_OD_MASK;
  end

  // register the pin controls
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_ff <= '0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign pinOut    = pin_ff.out;
  assign pinOe     = pin_ff.oe;
  assign pinPullup = pin_ff.pu;

  a_pu_input_only: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (pin_ff.pu & $past(dir)) == '0)
    else $error("pull-up left on an output pin");

  a_pu_whole_group: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $past(pur[8]) && ($past(dir[35:32]) == 4'h0) && !$past(busMode)
      |-> pin_ff.pu[35:32] == 4'hF)
    else $error("group pull-up not applied to all four pins");

  a_bus_pu_off: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $past(busMode) |-> (pin_ff.pu & `GPC_BUS_PU_MASK) == '0)
    else $error("pull-up on a bus pin in bus mode");

  a_open_drain: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (pin_ff.out[57:56] == 2'h0) && (pin_ff.pu[57:56] == 2'h0)
      && (pin_ff.oe[56] == ($past(dir[56]) && !$past(latch[56]))))
    else $error("open-drain pin driven high or pulled up");

  a_latch_driven: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $past(dir[80]) |-> pin_ff.oe[80] && (pin_ff.out[80] == $past(latch[80])))
    else $error("output latch not driven on pin");

endmodule : gpc_pin_stage

`default_nettype wire

// [src/gpc_port_ctrl.sv]
/*
  Port control core: direction and data registers of ports 0 to 14, the
  four pull-up select registers, port control, write protect and processor
  mode. Assumes a plain register port (read data one cycle after the read
  strobe) and pin inputs synchronous to mclk.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - one select bit covers four pins
// - pull-up only on selected input pins
// - extension ports need enable bit first
// - enable low clears extension port data
// - bus modes: bits kept, no pull-ups on pins 0-47 except 36-39
// - readback bit returns port 1 latch
// - bus pins ignore direction and data writes
// - port 7 pins 0,1 open drain
// - input pin reads its level
// - output pin drives its latch
// - port 8 bit 5 reads interrupt pin
// - entering bus mode from single-chip mode sets bus pull-up
// - hardware reset loads from boot pin
// - soft resets load from current mode
// - no extension ports: enable stays zero
// - direction one output, zero input
// - output pin reads its latch
module gpc_port_ctrl
  import gpc_pkg::*;
#(
  parameter logic HAS_EXT_PORTS = 1'h1
)
(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  // reset causes and straps
  input  wire logic                      softReset,
  input  wire logic                      bootModePin,
  // register port
  input  wire logic [9:0]                regAddr,
  input  wire logic [7:0]                regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic [7:0]                     regRdata,
  // mode status
  output gpc_pkg::gpc_mode_t             procMode,
  // pins
  input  wire logic [`GPC_PORT_PINS-1:0] pinIn,
  output logic [`GPC_PORT_PINS-1:0]      pinOut,
  output logic [`GPC_PORT_PINS-1:0]      pinOe,
  output logic [`GPC_PORT_PINS-1:0]      pinPullup
);

  import gpc_pkg::*;

  gpc_ctrl_t ctrl_ff;
  gpc_ctrl_t nxt_ctrl;

  logic       busMode;
  logic       nxtBusMode;
  logic       running;
  logic [3:0] dirIdx;
  logic [3:0] dataIdx;
  logic [7:0] pinByte;

  // true while the external bus owns the low ports
  function automatic logic isBusMode(input gpc_mode_t m);
    return (m == PM_EXPAND) || (m == PM_MICRO);
  endfunction : isBusMode

  // address falls into a 15-register port block
  function automatic logic portHit(input logic [9:0] a, input logic [9:0] base);
    return (a >= base) && (a <= 10'(base + `GPC_LAST_IDX));
  endfunction : portHit

  // port number inside a port block
  function automatic logic [3:0] portIdx(input logic [9:0] a, input logic [9:0] base);
    return 4'(a - base);
  endfunction : portIdx

  // bits of a port that writes must leave alone
  function automatic logic [7:0] lockMask(input logic [3:0] idx, input logic bus);
    logic [7:0] m;
    m = (bus && (idx <= 4'(`GPC_BUS_LAST))) ? 8'hFF : 8'h00;
    if (idx == `GPC_PORT8) begin
      m[`GPC_NMI_BIT] = 1'h1;
    end
    if (!HAS_EXT_PORTS && (idx >= 4'(`GPC_EXT_FIRST))) begin
      m = 8'hFF;
    end
    return m;
  endfunction : lockMask

  // pull-up register b value chosen by a processor mode
  function automatic logic [7:0] purBReset(input gpc_mode_t m);
    return isBusMode(m) ? `GPC_PURB_BUS : `GPC_PURB_SINGLE;
  endfunction : purBReset

  // decode helpers
  assign busMode    = isBusMode(ctrl_ff.pmode);
  assign nxtBusMode = isBusMode(nxt_ctrl.pmode);
  assign running    = (ctrl_ff.phase == PH_RUN);
  assign dirIdx     = portIdx(regAddr, `GPC_DIR_BASE);
  assign dataIdx    = portIdx(regAddr, `GPC_DATA_BASE);
  assign pinByte    = pinIn[{dataIdx, 3'h0} +: 8];

  // next-state logic: strap capture, soft reset, writes and reads
  always_comb begin
    logic [7:0] keep;
    logic [7:0] sel;
    logic [7:0] rd;
    gpc_mode_t  newMode;
    keep    = 8'h00;
    sel     = 8'h00;
    rd      = 8'h00;
    newMode = PM_SINGLE;
    nxt_ctrl       = ctrl_ff;
    nxt_ctrl.rdata = 8'h00;
    case (ctrl_ff.phase)
      PH_STRAP: begin
        // boot pin sampled on the first edge after release
        nxt_ctrl.phase  = PH_RUN;
        nxt_ctrl.pmode  = bootModePin ? PM_MICRO : PM_SINGLE;
        nxt_ctrl.pur[1] = bootModePin ? `GPC_PURB_BUS : `GPC_PURB_SINGLE;
      end
      PH_RUN: begin
        if (softReset) begin
          // soft resets keep the processor mode
          nxt_ctrl.dir       = '0;
          nxt_ctrl.latch     = '0;
          nxt_ctrl.pur       = '0;
          nxt_ctrl.pur[1]    = purBReset(ctrl_ff.pmode);
          nxt_ctrl.latchRb   = 1'h0;
          nxt_ctrl.protRel   = 1'h0;
          nxt_ctrl.busClkOff = 1'h0;
        end else begin
          if (regWr) begin
            // any write other than to the protect register ends the release
            nxt_ctrl.protRel = 1'h0;
            if (portHit(regAddr, `GPC_DIR_BASE)) begin
              keep = lockMask(dirIdx, busMode);
              if ((dirIdx != `GPC_PORT9) || ctrl_ff.protRel) begin
                nxt_ctrl.dir[dirIdx] = (ctrl_ff.dir[dirIdx] & keep)
                                     | (regWdata & ~keep);
              end
            end
            if (portHit(regAddr, `GPC_DATA_BASE)) begin
              keep = lockMask(dataIdx, busMode);
              nxt_ctrl.latch[dataIdx] = (ctrl_ff.latch[dataIdx] & keep)
                                      | (regWdata & ~keep);
            end
            for (int k = 0; k < 4; k++) begin
              if (regAddr == 10'(`GPC_PUR_BASE + k)) begin
                nxt_ctrl.pur[k] = regWdata;
              end
            end
            if ((regAddr == 10'(`GPC_PUR_BASE + 3)) && !HAS_EXT_PORTS) begin
              nxt_ctrl.pur[3][`GPC_EXT_EN_BIT] = 1'h0;
            end
            if (regAddr == `GPC_PORT_CTRL) begin
              nxt_ctrl.latchRb = regWdata[`GPC_LATCH_RB];
            end
            if (regAddr == `GPC_WR_PROTECT) begin
              nxt_ctrl.protRel = regWdata[`GPC_PROT_REL_BIT];
            end
            if (regAddr == `GPC_PROC_MODE) begin
              newMode            = gpc_mode_t'(regWdata[1:0]);
              nxt_ctrl.pmode     = newMode;
              nxt_ctrl.busClkOff = regWdata[`GPC_BCLK_OFF];
              if ((ctrl_ff.pmode == PM_SINGLE) && isBusMode(newMode)) begin
                nxt_ctrl.pur[1][`GPC_BUS_PU_BIT] = 1'h1;
              end
            end
          end
          if (regRd) begin
            if (portHit(regAddr, `GPC_DATA_BASE)) begin
              sel = ctrl_ff.dir[dataIdx];
              if ((dataIdx == `GPC_PORT1) && ctrl_ff.latchRb) begin
                sel = 8'hFF;
              end
              if (dataIdx == `GPC_PORT8) begin
                sel[`GPC_NMI_BIT] = 1'h0;
              end
              rd = (ctrl_ff.latch[dataIdx] & sel) | (pinByte & ~sel);
              if (!HAS_EXT_PORTS && (dataIdx >= 4'(`GPC_EXT_FIRST))) begin
                rd = 8'h00;
              end
            end else if (portHit(regAddr, `GPC_DIR_BASE)) begin
              rd = ctrl_ff.dir[dirIdx];
            end else if (regAddr == `GPC_PORT_CTRL) begin
              rd = {7'h00, ctrl_ff.latchRb};
            end else if (regAddr == `GPC_WR_PROTECT) begin
              rd = 8'h00;
              rd[`GPC_PROT_REL_BIT] = ctrl_ff.protRel;
            end else if (regAddr == `GPC_PROC_MODE) begin
              rd = {ctrl_ff.busClkOff, 5'h00, ctrl_ff.pmode};
            end else begin
              for (int k = 0; k < 4; k++) begin
                if (regAddr == 10'(`GPC_PUR_BASE + k)) begin
                  rd = ctrl_ff.pur[k];
                end
              end
            end
            nxt_ctrl.rdata = rd;
          end
        end
      end
      default: begin
        nxt_ctrl.phase = PH_STRAP;
      end
    endcase
    // extension ports hold zero while disabled
    if (!nxt_ctrl.pur[3][`GPC_EXT_EN_BIT]) begin
      nxt_ctrl.latch[`GPC_NUM_PORTS-1:`GPC_EXT_FIRST] = '0;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign regRdata = ctrl_ff.rdata;
  assign procMode = ctrl_ff.pmode;

  // pin stage follows the next register image so pins move on the write edge
  gpc_pin_stage u_pin_stage (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .dir       (nxt_ctrl.dir),
    .latch     (nxt_ctrl.latch),
    .pur       (nxt_ctrl.pur),
    .busMode   (nxtBusMode),
    .pinOut    (pinOut),
    .pinOe     (pinOe),
    .pinPullup (pinPullup)
  );

  a_ext_clear: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !ctrl_ff.pur[3][`GPC_EXT_EN_BIT] |-> ctrl_ff.latch[14:11] == '0)
    else $error("extension port data not cleared");

  a_p1_readback: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regRd && running && !softReset && ctrl_ff.latchRb
      && (regAddr == 10'(`GPC_DATA_BASE + 10'h001))
      |=> regRdata == $past(ctrl_ff.latch[1]))
    else $error("port 1 read ignored latch readback");

  a_nmi_bit: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regRd && running && !softReset && (regAddr == `GPC_PORT8_DATA)
      |=> regRdata[`GPC_NMI_BIT] == $past(pinIn[`GPC_NMI_PIN]))
    else $error("port 8 bit 5 does not show interrupt pin");

  a_bus_lock: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regWr && running && !softReset && busMode && (regAddr == `GPC_DIR_BASE)
      |=> $stable(ctrl_ff.dir[0]))
    else $error("bus pin direction changed in bus mode");

  a_p9_guard: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regWr && running && !softReset && !ctrl_ff.protRel
      && (regAddr == 10'(`GPC_DIR_BASE + 10'h009))
      |=> $stable(ctrl_ff.dir[9]))
    else $error("port 9 direction written while protected");

  a_mode_pullup: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regWr && running && !softReset && (ctrl_ff.pmode == PM_SINGLE)
      && (regAddr == `GPC_PROC_MODE) && (regWdata[1:0] == 2'h1)
      |=> ctrl_ff.pur[1][`GPC_BUS_PU_BIT])
    else $error("bus group pull-up not set on mode change");

  a_strap_load: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (ctrl_ff.phase == PH_STRAP) ##1 running
      |-> ctrl_ff.pur[1] == ($past(bootModePin) ? `GPC_PURB_BUS : `GPC_PURB_SINGLE))
    else $error("pull-up register b wrong after hardware reset");

  a_strap_mode: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (ctrl_ff.phase == PH_STRAP) ##1 running
      |-> procMode == ($past(bootModePin) ? PM_MICRO : PM_SINGLE))
    else $error("processor mode not taken from boot pin");

  a_soft_mode_kept: assert property (
    @(posedge mclk) disable iff (!reset_n)
    softReset && running |=> $stable(ctrl_ff.pmode))
    else $error("soft reset changed the processor mode");

  a_rdata_idle: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !regRd |=> regRdata == 8'h00)
    else $error("read data not cleared outside a read");

  a_prot_one_shot: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regWr && running && !softReset && (regAddr != `GPC_WR_PROTECT)
      |=> !ctrl_ff.protRel)
    else $error("protect release outlived the next write");

  a_dir_write: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regWr && running && !softReset && !busMode
      && (regAddr == 10'(`GPC_DIR_BASE + 10'h002))
      |=> ctrl_ff.dir[2] == $past(regWdata))
    else $error("direction write did not land on its edge");

  a_pur_writable: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regWr && running && !softReset && (regAddr == `GPC_PUR_BASE)
      |=> ctrl_ff.pur[0] == $past(regWdata))
    else $error("pull-up select write did not land");

  a_soft_load: assert property (
    @(posedge mclk) disable iff (!reset_n)
    softReset && running
      |=> ctrl_ff.pur[1] == ($past(busMode) ? `GPC_PURB_BUS : `GPC_PURB_SINGLE))
    else $error("pull-up register b wrong after soft reset");

  a_input_read: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regRd && running && !softReset && (ctrl_ff.dir[10] == 8'h00)
      && (regAddr == 10'(`GPC_DATA_BASE + 10'h00A))
      |=> regRdata == $past(pinIn[87:80]))
    else $error("input port read did not return pin level");

  a_output_read: assert property (
    @(posedge mclk) disable iff (!reset_n)
    regRd && running && !softReset && (ctrl_ff.dir[10] == 8'hFF)
      && (regAddr == 10'(`GPC_DATA_BASE + 10'h00A))
      |=> regRdata == $past(ctrl_ff.latch[10]))
    else $error("output port read did not return latch");

endmodule : gpc_port_ctrl

`default_nettype wire

// [verif/gpc_board_model.sv]
/*
  Board model: the circuitry on the far side of the port pins. It works out
  each pin level from the device drive, the board's own drive and the
  pull-up. Assumes the bench sets which pins the board drives.
*/
`timescale 1ns/100ps
`default_nettype none

module gpc_board_model (
  // device pin controls
  input  wire logic [119:0] pinOut,
  input  wire logic [119:0] pinOe,
  input  wire logic [119:0] pinPullup,
  // board side stimulus
  input  wire logic [119:0] boardDrive,
  input  wire logic [119:0] boardLevel,
  // pin levels seen by the device
  output logic [119:0]      pinIn
);
  // device drive wins, then board drive, then pull-up; a floating pin
  // shows the inverse of pinOut so a stale drive value never reads back
  always_comb begin
    pinIn = (pinOe & pinOut)
          | (~pinOe & boardDrive & boardLevel)
          | (~pinOe & ~boardDrive & pinPullup)
          | (~pinOe & ~boardDrive & ~pinPullup & ~pinOut);
  end
endmodule : gpc_board_model

`default_nettype wire

// [verif/gpc_port_ctrl_bench.sv]
/*
  Testbench of the port control core: drives the register port, the resets
  and a board model, and checks reads and pin controls. Assumes the design
  sources and gpc_cfg.svh are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gpc_cfg.svh"

module gpc_port_ctrl_bench;
  import gpc_pkg::*;

  logic               mclk;
  logic               reset_n;
  logic               softReset;
  logic               bootModePin;
  logic [9:0]         regAddr;
  logic [7:0]         regWdata;
  logic               regWr;
  logic               regRd;
  logic [7:0]         regRdata;
  gpc_mode_t          procMode;
  logic [119:0]       pinIn;
  logic [119:0]       pinOut;
  logic [119:0]       pinOe;
  logic [119:0]       pinPullup;
  logic [119:0]       boardDrive;
  logic [119:0]       boardLevel;
  int                 nFail;
  int                 checks;

  localparam logic [9:0] DIR = `GPC_DIR_BASE;
  localparam logic [9:0] DAT = `GPC_DATA_BASE;
  localparam logic [9:0] PUR = `GPC_PUR_BASE;

  gpc_port_ctrl #(.HAS_EXT_PORTS(1'h1)) u_gpc_port_ctrl (
    .mclk(mclk), .reset_n(reset_n), .softReset(softReset), .bootModePin(bootModePin),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .procMode(procMode), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinPullup(pinPullup));

  gpc_board_model u_gpc_board_model (
    .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup),
    .boardDrive(boardDrive), .boardLevel(boardLevel), .pinIn(pinIn));

  // clock generator
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    if (nFail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: pin control %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // one-cycle write, effect visible after the taking edge
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr    <= 1'h1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr    <= 1'h0;
    #1;
  endtask : wr

  // one-cycle read, data sampled in the cycle after the strobe
  task automatic rdChk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRd   <= 1'h1;
    regAddr <= a;
    @(posedge mclk);
    regRd   <= 1'h0;
    #1;
    chk8(regRdata, exp);
  endtask : rdChk

  task automatic t_reset;
    chk8({6'h00, procMode}, 8'h00);
    rdChk(PUR + 10'h001, `GPC_PURB_SINGLE);
    rdChk(10'h3FF, 8'h00);
  endtask : t_reset

  task automatic t_data;
    wr(DIR + 10'h002, 8'h0F);
    wr(DAT + 10'h002, 8'hA5);
    chk1(pinOe[16], 1'h1);
    chk1(pinOe[20], 1'h0);
    chk1(pinOut[17], 1'h0);
    rdChk(DAT + 10'h002, 8'hF5);
  endtask : t_data

  task automatic t_pull;
    boardDrive[23:16] = 8'h00;
    wr(PUR, 8'h30);
    chk1(pinPullup[17], 1'h0);
    chk1(pinPullup[21], 1'h1);
    chk1(pinPullup[23], 1'h1);
    rdChk(DAT + 10'h002, 8'hF5);
  endtask : t_pull

  task automatic t_readback;
    boardLevel[15:8] = 8'h00;
    wr(DIR + 10'h001, 8'h00);
    wr(DAT + 10'h001, 8'h3C);
    rdChk(DAT + 10'h001, 8'h00);
    wr(`GPC_PORT_CTRL, 8'h01);
    rdChk(DAT + 10'h001, 8'h3C);
    @(posedge mclk);
    #1;
    chk8(regRdata, 8'h00);
  endtask : t_readback

  task automatic t_ext;
    wr(DIR + 10'h00B, 8'hFF);
    wr(DAT + 10'h00B, 8'hFF);
    rdChk(DAT + 10'h00B, 8'h00);
    wr(PUR + 10'h003, 8'h80);
    wr(DAT + 10'h00B, 8'hC3);
    rdChk(DAT + 10'h00B, 8'hC3);
    wr(PUR + 10'h003, 8'h00);
    rdChk(DAT + 10'h00B, 8'h00);
  endtask : t_ext

  task automatic t_nmi;
    boardLevel[69] = 1'h1;
    wr(DIR + 10'h008, 8'hFF);
    wr(`GPC_PORT8_DATA, 8'hFF);
    rdChk(`GPC_PORT8_DATA, 8'hFF);
    boardLevel[69] = 1'h0;
    rdChk(`GPC_PORT8_DATA, 8'hDF);
    chk1(pinOe[69], 1'h0);
  endtask : t_nmi

  task automatic t_od;
    wr(DIR + 10'h007, 8'h03);
    wr(DAT + 10'h007, 8'h02);
    chk1(pinOe[56], 1'h1);
    chk1(pinOut[56], 1'h0);
    chk1(pinOe[57], 1'h0);
    boardDrive[59:56] = 4'h0;
    wr(DIR + 10'h007, 8'h00);
    wr(PUR + 10'h001, 8'h41);
    chk1(pinPullup[56], 1'h0);
    chk1(pinPullup[33], 1'h1);
    chk1(pinPullup[58], 1'h1);
  endtask : t_od

  task automatic t_prot;
    wr(DIR + 10'h009, 8'hFF);
    rdChk(DIR + 10'h009, 8'h00);
    wr(`GPC_WR_PROTECT, 8'h04);
    wr(DIR + 10'h009, 8'hFF);
    rdChk(DIR + 10'h009, 8'hFF);
    wr(DIR + 10'h009, 8'h00);
    rdChk(DIR + 10'h009, 8'hFF);
  endtask : t_prot

  task automatic t_bus;
    wr(DIR + 10'h004, 8'h00);
    wr(`GPC_PROC_MODE, 8'h01);
    chk8({6'h00, procMode}, 8'h01);
    chk1(pinPullup[37], 1'h1);
    rdChk(PUR + 10'h001, 8'h43);
    rdChk(PUR, 8'h30);
    chk1(pinPullup[21], 1'h0);
    chk1(pinPullup[33], 1'h0);
    wr(DIR, 8'hFF);
    rdChk(DIR, 8'h00);
  endtask : t_bus

  task automatic t_soft;
    @(posedge mclk);
    softReset <= 1'h1;
    @(posedge mclk);
    softReset <= 1'h0;
    #1;
    chk8({6'h00, procMode}, 8'h01);
    rdChk(PUR + 10'h001, `GPC_PURB_BUS);
    rdChk(PUR, 8'h00);
  endtask : t_soft

  // input then output use of a port with no special handling
  task automatic t_port10;
    boardLevel[87:80] = 8'h96;
    rdChk(DAT + 10'h00A, 8'h96);
    wr(DIR + 10'h00A, 8'hFF);
    wr(DAT + 10'h00A, 8'h5A);
    chk1(pinOe[80], 1'h1);
    chk1(pinOut[81], 1'h1);
    rdChk(DAT + 10'h00A, 8'h5A);
  endtask : t_port10

  // second hardware reset in mid-run with the boot pin high
  task automatic t_boot;
    @(posedge mclk);
    reset_n     <= 1'h0;
    bootModePin <= 1'h1;
    repeat (3) @(posedge mclk);
    reset_n     <= 1'h1;
    repeat (2) @(posedge mclk);
    #1;
    chk8({6'h00, procMode}, 8'h03);
    chk1(pinPullup[37], 1'h1);
    rdChk(PUR + 10'h001, `GPC_PURB_BUS);
  endtask : t_boot

  // main sequence
  initial begin
    nFail = 0;
    checks = 0;
    reset_n = 1'h0;
    softReset = 1'h0;
    bootModePin = 1'h0;
    regAddr = 10'h000;
    regWdata = 8'h00;
    regWr = 1'h0;
    regRd = 1'h0;
    boardDrive = {120{1'h1}};
    boardLevel = {120{1'h1}};
    repeat (3) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_data();
    t_port10();
    t_pull();
    t_readback();
    t_ext();
    t_nmi();
    t_od();
    t_prot();
    t_bus();
    t_soft();
    t_boot();
    tally_and_finish();
  end

  // watchdog cutting a hang short
  initial begin
    #100000;
    nFail++;
    tally_and_finish();
  end
endmodule : gpc_port_ctrl_bench

`default_nettype wire
